/* dv/watchdog_reset_flags_tb.sv */
// Testbench joining both ends of the watchdog link
`default_nettype none
module watchdog_reset_flags_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import wdg_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n = 1'b0;
   logic fuse = 1'b0;
   logic [4:0] pls = 5'h00; // poweron, pin, brownout, restart, irq_ack
   logic [1:0] wsel = WDG_SEL_NONE;
   logic [7:0] wdat = 8'h00;
   logic [7:0] cause;
   logic [7:0] ctrl;
   logic irq_out;
   logic sys_reset_out;
   int error_cnt = 0;
   int cmp_count = 0;
   int rst_seen = 0;
   int n;
   wdg_link_if link();
   // Short divider keeps the time-outs to a few thousand clocks
   wdg_dog #(.OSC_DIV(2)) i_wdg_dog (.clk_in(clk_in), .rst_n_in(rst_n), .poweron_in(pls[0]),
      .pin_reset_in(pls[1]), .brownout_in(pls[2]), .dog_always_on_fuse_in(fuse), .link(link));
   wdg_core i_wdg_core (.clk_in(clk_in), .rst_n_in(rst_n), .restart_in(pls[3]),
      .wr_sel_in(wsel), .wr_data_in(wdat), .irq_ack_in(pls[4]), .cause_out(cause),
      .ctrl_out(ctrl), .irq_out(irq_out), .sys_reset_out(sys_reset_out), .link(link));
   wdg_link_monitor i_wdg_link_monitor (.clk_in(clk_in), .rst_n_in(rst_n),
      .restart(link.restart), .wr_sel(link.wr_sel), .wr_data(link.wr_data),
      .cause_rd(link.cause_rd), .ctrl_rd(link.ctrl_rd), .irq(link.irq),
      .irq_ack(link.irq_ack), .sys_reset(link.sys_reset));
   ////////////////////////////////////////
   // Clock and a count of reset pulses
   always #20 clk_in = ~clk_in;
   always @(posedge clk_in)
   begin
      if (sys_reset_out === 1'b1)
         rst_seen++;
   end
   task automatic pulse(input int b);
      @(negedge clk_in);
      pls[b] = 1'b1;
      @(negedge clk_in);
      pls = 5'h00;
   endtask
   // One-cycle write; back-to-back calls land two edges apart, inside the window
   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      @(negedge clk_in);
      wsel = s;
      wdat = d;
      @(negedge clk_in);
      wsel = WDG_SEL_NONE;
   endtask
   // Register copy trails the link by one more cycle
   task automatic settle;
      repeat (3) @(negedge clk_in);
   endtask
   task automatic wt(input bit rs, output int cnt);
      cnt = 0;
      while (((rs ? sys_reset_out : ctrl[7]) !== 1'b1) && cnt < 20000)
      begin
         @(negedge clk_in);
         cnt++;
      end
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (16) @(negedge clk_in);
      rst_n = 1'b1;
      pulse(0);
      pulse(1);
      pulse(2);
      settle;
      chk(cause, 8'h07);
      pulse(0);
      settle;
      chk(cause, 8'h01);
      wr(WDG_SEL_CAUSE, 8'h00);
      settle;
      chk(cause, 8'h00);
      wr(WDG_SEL_CTRL, 8'h18);
      wr(WDG_SEL_CTRL, 8'h40);
      pulse(3);
      repeat (3000) @(negedge clk_in);
      pulse(3);
      wt(1'b0, n);
      chk(8'(n > 4080 && n < 4112), 8'h01);
      chk({7'h00, irq_out}, 8'h01);
      chk(8'(rst_seen), 8'h00);
      pulse(4);
      wr(WDG_SEL_CTRL, 8'h45);
      settle;
      chk(ctrl & 8'hAF, 8'h00);
      // Combined mode: interrupt first, reset on the next expiry
      pulse(3);
      wr(WDG_SEL_CTRL, 8'h18);
      wr(WDG_SEL_CTRL, 8'h49);
      settle;
      chk(ctrl & 8'h6F, 8'h49);
      pulse(3);
      wt(1'b0, n);
      chk(8'(n > 8176 && n < 8208), 8'h01);
      chk(ctrl & 8'hC8, 8'hC8);
      chk({7'h00, irq_out}, 8'h01);
      pulse(4);
      settle;
      chk(ctrl & 8'hC8, 8'h08);
      wt(1'b1, n);
      chk(8'(n > 8100 && n < 8208), 8'h01);
      settle;
      chk(cause, 8'h08);
      chk(8'(rst_seen), 8'h01);
      wr(WDG_SEL_CTRL, 8'h18);
      wr(WDG_SEL_CTRL, 8'h00);
      settle;
      chk(ctrl & 8'h08, 8'h08);
      wr(WDG_SEL_CAUSE, 8'h00);
      wr(WDG_SEL_CTRL, 8'h18);
      wr(WDG_SEL_CTRL, 8'h00);
      settle;
      chk(ctrl & 8'h2F, 8'h00);
      fuse = 1'b1;
      wr(WDG_SEL_CTRL, 8'h18);
      wr(WDG_SEL_CTRL, 8'h40);
      settle;
      chk(ctrl & 8'h48, 8'h08);
      results;
   end
   // Hang guard, about twice the expected run
   initial
   begin
      #2_000_000;
      error_cnt++;
      results;
   end
endmodule
`default_nettype wire

/* dv/wdg_link_monitor.sv */
// Checker watching the link between the watchdog and the core
`default_nettype none
module wdg_link_monitor
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic restart,
   input wire logic [1:0] wr_sel,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] cause_rd,
   input wire logic [7:0] ctrl_rd,
   input wire logic irq,
   input wire logic irq_ack,
   input wire logic sys_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////
   // Pulses and forced bits
   reset_pulse_a: assert property (sys_reset |=> !sys_reset)
      else $error("reset pulse too long");
   dog_flag_a: assert property (sys_reset |-> ##[0:1] cause_rd[3])
      else $error("dog cause flag missing");
   rst_en_held_a: assert property (cause_rd[3] |-> ctrl_rd[3])
      else $error("reset enable not forced");
   irq_level_a: assert property (irq == (ctrl_rd[7] && ctrl_rd[6]))
      else $error("irq not flag and enable");
   vector_clear_a: assert property (irq_ack && ctrl_rd[7] |=> !ctrl_rd[7])
      else $error("flag kept after vector");
   combined_drop_a: assert property (irq_ack && ctrl_rd[3] |=> !ctrl_rd[6])
      else $error("irq enable kept after vector");
   // Restart keeps expiry away for a while
   restart_quiet_a: assert property (restart |=> !sys_reset [*8])
      else $error("reset right after restart");
   ////////////////////////////////////////
   // Change window, opened by the unlock write only
   window_open_a: assert property (wr_sel == 2'h2 && wr_data[4] && wr_data[3]
      |=> ctrl_rd[4])
      else $error("window did not open");
   window_close_a: assert property ($rose(ctrl_rd[4]) |-> ##[1:4] !ctrl_rd[4])
      else $error("window stayed open");
   locked_pre_a: assert property (wr_sel == 2'h2 && !ctrl_rd[4] && !wr_data[4]
      |=> {ctrl_rd[5], ctrl_rd[2:0]} == $past({ctrl_rd[5], ctrl_rd[2:0]}))
      else $error("prescale changed while locked");
   cover property (sys_reset);
   cover property (irq);
   cover property ($rose(ctrl_rd[4]));
endmodule
`default_nettype wire

/* hdl/wdg_core.sv */
// Core-side end: drives restarts, register writes and vector acknowledge
`default_nettype none
module wdg_core
   import wdg_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic restart_in,
   input wire logic [1:0] wr_sel_in,
   input wire logic [7:0] wr_data_in,
   input wire logic irq_ack_in,
   output logic [7:0] cause_out,
   output logic [7:0] ctrl_out,
   output logic irq_out,
   output logic sys_reset_out,
   wdg_link_if.core link
);
   import wdg_pkg::*;

   typedef struct packed {
      logic [7:0] cause;
      logic [7:0] ctrl;
   } wdg_core_t;

   wdg_core_t st_r;
   wdg_core_t st_nxt;

   ////////////////////////////////////////////////////////////////
   // Requests pass straight through; the software sequence lives above
   assign link.restart = restart_in; // [RL7] [RL17]
   assign link.wr_sel = wr_sel_in; // [RL12] [RL13] [RL4] [RL16]
   assign link.wr_data = wr_data_in;
   assign link.irq_ack = irq_ack_in;
   assign irq_out = link.irq;
   assign sys_reset_out = link.sys_reset;

   // Register the read views so data outputs come from flops
   always_comb
   begin
      st_nxt.cause = link.cause_rd;
      st_nxt.ctrl = link.ctrl_rd;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign cause_out = st_r.cause;
   assign ctrl_out = st_r.ctrl;
endmodule
`default_nettype wire

/* hdl/wdg_dog.sv */
// Watchdog timer with reset-cause status, the documented device end
// How it works
// [RL1] Brown-out sets bit 2; poweron or zero-write clears
// [RL2] Pin reset sets bit 1; poweron, zero-write clear
// [RL3] Poweron sets bit 0; only zero-write clears (here rst_n_in also clears it)
// [RL4] Software reads then clears cause flags early
// [RL5] Counter ticks on 128 kHz enable
// [RL6] Expiry raises the current mode's action
// [RL7] Restart instruction zeroes the counter
// [RL8] Interrupt mode: flag and wake, no reset
// [RL9] Reset mode: expiry resets the system
// [RL10] Combined mode: interrupt, then reset mode
// [RL11] Fuse forces reset-enable one, irq-enable zero
// [RL12] Unlock writes change-enable and reset-enable together
// [RL13] Protected update accepted within four cycles
// [RL14] Time-out spans 16 ms to 8 s
// [RL15] After dog reset, reset mode stays on
// [RL16] Init software clears dog flag, then reset-enable
// [RL17] Restart counter before changing prescaler
// [RL18] Dog reset sets bit 3; poweron, zero-write clear
// [RL19] Dog cause flag forces reset-enable high
// [RL20] Change-enable self-clears after four cycles
// [RL21] Prescaler 0..9 gives 2048 doubling ticks
// [RL22] Locked writes cannot clear reset-enable or prescaler
`default_nettype none
module wdg_dog
   import wdg_pkg::*;
#(
   parameter int OSC_DIV = WDG_OSC_DIV
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic poweron_in,
   input wire logic pin_reset_in,
   input wire logic brownout_in,
   input wire logic dog_always_on_fuse_in,
   wdg_link_if.dog link
);
   import wdg_pkg::*;

   typedef struct packed {
      logic [15:0] div;
      logic [20:0] count;
      logic [7:0] cause;
      logic [3:0] prescale;
      logic rst_en;
      logic irq_en;
      logic irq_flag;
      logic [2:0] chg_cnt;
      logic sys_reset;
   } wdg_state_t;

   wdg_state_t st_r;
   wdg_state_t st_nxt;
   logic tick;
   logic expire;
   logic [20:0] limit;
   logic [7:0] d;
   logic act_reset;
   logic act_irq;

   ////////////////////////////////////////////////////////////////
   // Time-out limit; reserved codes fall back to the longest period
   always_comb
   begin
      if (st_r.prescale > WDG_PRESCALE_MAX)
         limit = 21'(WDG_BASE_TICKS) << WDG_PRESCALE_MAX; // [RL21]
      else
         limit = 21'(WDG_BASE_TICKS) << st_r.prescale; // [RL21] [RL14]
   end

   // One clock only: the slow oscillator rate is an enable pulse
   // from the divider, so the timer needs no second clock domain
   assign tick = (st_r.div == 16'(OSC_DIV - 1)); // [RL5]
   assign expire = tick && (st_r.count + 21'h1 >= limit); // [RL6]
   assign d = link.wr_data;

   ////////////////////////////////////////////////////////////////
   // Expiry action decode. An interrupt still pending at the next
   // expiry means its handler never ran, so combined mode falls
   // through to a reset rather than raising the flag once more.
   always_comb
   begin
      act_reset = 1'b0;
      act_irq = 1'b0;
      if (expire)
      begin
         if (dog_always_on_fuse_in)
            act_reset = 1'b1; // Fuse overrides both enables [RL11]
         else if (st_r.rst_en && (!st_r.irq_en || st_r.irq_flag))
            act_reset = 1'b1; // [RL9] [RL10]
         else if (st_r.irq_en)
            act_irq = 1'b1; // [RL8]
      end
   end

   ////////////////////////////////////////////////////////////////
   // Next-state logic for the whole block
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.sys_reset = 1'b0;
      st_nxt.div = tick ? 16'h0000 : st_r.div + 16'h0001; // [RL5]
      // Counter: restart wins over ticking
      if (link.restart)
         st_nxt.count = 21'h000000; // [RL7]
      else if (expire)
         st_nxt.count = 21'h000000;
      else if (tick)
         st_nxt.count = st_r.count + 21'h000001; // [RL5]
      // Change window countdown
      if (st_r.chg_cnt != 3'h0)
         st_nxt.chg_cnt = st_r.chg_cnt - 3'h1; // [RL20]
      // Cause register write: zero clears, one leaves alone
      if (link.wr_sel == WDG_SEL_CAUSE)
         st_nxt.cause = st_r.cause & {4'h0, d[3:0]}; // [RL1] [RL2] [RL3] [RL18]
      // Control register write; a locked write may still set rst_en
      // and always reaches the interrupt bits
      if (link.wr_sel == WDG_SEL_CTRL)
      begin
         st_nxt.irq_en = d[WDG_CTL_IRQ_EN_BIT];
         if (d[WDG_CTL_IRQ_FLAG_BIT])
            st_nxt.irq_flag = 1'b0; // One clears the flag
         if (d[WDG_CTL_CHG_EN_BIT] && d[WDG_CTL_RST_EN_BIT])
         begin
            st_nxt.rst_en = 1'b1;
            st_nxt.chg_cnt = 3'(WDG_CHG_WINDOW_CYC); // [RL13] [RL20]
         end
         else if (st_r.chg_cnt != 3'h0 && !d[WDG_CTL_CHG_EN_BIT])
         begin
            st_nxt.rst_en = d[WDG_CTL_RST_EN_BIT]; // [RL13]
            st_nxt.prescale = {d[WDG_CTL_PRE3_BIT], d[WDG_CTL_PRE2_BIT],
               d[WDG_CTL_PRE1_BIT], d[WDG_CTL_PRE0_BIT]};
            st_nxt.chg_cnt = 3'h0;
         end
         else if (d[WDG_CTL_RST_EN_BIT])
            st_nxt.rst_en = 1'b1; // Setting is always allowed [RL22]
      end
      // Interrupt acknowledge by vector entry
      if (link.irq_ack)
      begin
         st_nxt.irq_flag = 1'b0;
         if (st_r.rst_en)
            st_nxt.irq_en = 1'b0; // Combined mode drops to reset mode [RL10]
      end
      // Expiry action; set beats clear
      if (act_reset)
      begin
         st_nxt.sys_reset = 1'b1; // [RL9] [RL6]
         st_nxt.cause[WDG_CAUSE_DOG_BIT] = 1'b1; // [RL18]
         st_nxt.rst_en = 1'b1; // [RL15]
         st_nxt.irq_en = 1'b0; // Leaves plain reset mode [RL15]
         st_nxt.irq_flag = 1'b0;
      end
      else if (act_irq)
         st_nxt.irq_flag = 1'b1; // Enable stays until the vector runs [RL8] [RL10]
      // External causes win over a same-cycle zero-write clear; a same-cycle poweron still clears them
      if (pin_reset_in)
         st_nxt.cause[WDG_CAUSE_PIN_BIT] = 1'b1; // [RL2]
      if (brownout_in)
         st_nxt.cause[WDG_CAUSE_BROWNOUT_BIT] = 1'b1; // [RL1]
      // Power-on restores the configuration and keeps only its own flag
      if (poweron_in)
      begin
         st_nxt.cause = 8'h01; // [RL3] [RL1] [RL2] [RL18]
         st_nxt.rst_en = 1'b0;
         st_nxt.irq_en = 1'b0;
         st_nxt.irq_flag = 1'b0;
         st_nxt.prescale = WDG_PRESCALE_RESET;
         st_nxt.count = 21'h000000;
         st_nxt.chg_cnt = 3'h0;
      end
      // Overrides applied last
      if (st_nxt.cause[WDG_CAUSE_DOG_BIT])
         st_nxt.rst_en = 1'b1; // [RL19]
      if (dog_always_on_fuse_in)
      begin
         st_nxt.rst_en = 1'b1; // [RL11]
         st_nxt.irq_en = 1'b0; // [RL11]
      end
   end

   ////////////////////////////////////////////////////////////////
   // State register; rst_n_in clears everything, cause flags too,
   // so a power-on is recorded only through poweron_in
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read views and strobes; bit 4 reads back as the open window,
   // so software can tell whether the update slot is still open
   assign link.cause_rd = {4'h0, st_r.cause[3:0]};
   assign link.ctrl_rd = {st_r.irq_flag, st_r.irq_en, st_r.prescale[3],
      (st_r.chg_cnt != 3'h0), st_r.rst_en, st_r.prescale[2:0]};
   assign link.irq = st_r.irq_flag && st_r.irq_en; // Wakes from sleep [RL8]
   assign link.sys_reset = st_r.sys_reset;
endmodule
`default_nettype wire

/* hdl/wdg_link_if.sv */
// Interface joining the watchdog block to the core that drives it
`default_nettype none
interface wdg_link_if;
   logic restart;
   logic [1:0] wr_sel;
   logic [7:0] wr_data;
   logic [7:0] cause_rd;
   logic [7:0] ctrl_rd;
   logic irq;
   logic irq_ack;
   logic sys_reset;
   modport dog (input restart, input wr_sel, input wr_data, input irq_ack,
      output cause_rd, output ctrl_rd, output irq, output sys_reset);
   modport core (output restart, output wr_sel, output wr_data, output irq_ack,
      input cause_rd, input ctrl_rd, input irq, input sys_reset);
endinterface
`default_nettype wire

/* hdl/wdg_pkg.sv */
// Package for the watchdog and reset-cause block: offsets, fields, timing
`default_nettype none
package wdg_pkg;
   // Register selects on the shared register port (no bus documented)
   localparam logic [1:0] WDG_SEL_NONE = 2'h0;
   localparam logic [1:0] WDG_SEL_CAUSE = 2'h1;
   localparam logic [1:0] WDG_SEL_CTRL = 2'h2;
   // reset_cause_status fields
   localparam int WDG_CAUSE_POWERON_BIT = 0;
   localparam int WDG_CAUSE_PIN_BIT = 1;
   localparam int WDG_CAUSE_BROWNOUT_BIT = 2;
   localparam int WDG_CAUSE_DOG_BIT = 3;
   localparam logic [7:0] WDG_CAUSE_RESET = 8'h00;
   // dog_control_status fields
   localparam int WDG_CTL_PRE0_BIT = 0;
   localparam int WDG_CTL_PRE1_BIT = 1;
   localparam int WDG_CTL_PRE2_BIT = 2;
   localparam int WDG_CTL_RST_EN_BIT = 3;
   localparam int WDG_CTL_CHG_EN_BIT = 4;
   localparam int WDG_CTL_PRE3_BIT = 5;
   localparam int WDG_CTL_IRQ_EN_BIT = 6;
   localparam int WDG_CTL_IRQ_FLAG_BIT = 7;
   localparam logic [3:0] WDG_PRESCALE_RESET = 4'h0;
   localparam logic [3:0] WDG_PRESCALE_MAX = 4'h9;
   // Timing
   localparam int WDG_CLK_HZ = 25_000_000;
   localparam int WDG_OSC_HZ = 128_000;
   localparam int WDG_OSC_DIV = (WDG_CLK_HZ + WDG_OSC_HZ / 2) / WDG_OSC_HZ;
   localparam int WDG_BASE_TICKS = 2048;
   localparam int WDG_CHG_WINDOW_CYC = 4;
   localparam int WDG_MIN_TIMEOUT_MS = 16;
   localparam int WDG_MAX_TIMEOUT_S = 8;
endpackage
`default_nettype wire
